// file: include/tpu_defines.svh
`ifndef TPU_DEFINES_SVH
`define TPU_DEFINES_SVH

// Register offsets
`define TPU_OFS_BASE_EN     8'h20
`define TPU_OFS_BASE_STAT   8'h21
`define TPU_OFS_PRESC       8'h23
`define TPU_OFS_T0_MODE     8'h24
`define TPU_OFS_T0_COUNT    8'h25
`define TPU_OFS_T1_MODE     8'h26
`define TPU_OFS_T1_COUNT    8'h27
`define TPU_OFS_IRQ_REQ     8'h3c
`define TPU_OFS_IRQ_EN      8'h3e

// Field positions
`define TPU_BIT_PRESC_CLEAR 7
`define TPU_BIT_PRESC_RUN   6
`define TPU_BIT_PRESC_SRC   5
`define TPU_BIT_STAT_CLEAR  7
`define TPU_BIT_TM_RELOAD   4
`define TPU_BIT_T0_ENABLE   5
`define TPU_BIT_T1_LF       3
`define TPU_BIT_IRQ_T0      2
`define TPU_BIT_IRQ_T1      3
`define TPU_BIT_IRQ_BT      5

// Reset values and writable masks
`define TPU_RST_BYTE        8'h00
`define TPU_MASK_T0_MODE    8'h37
`define TPU_MASK_T1_MODE    8'h1f
`define TPU_MASK_IRQ        8'h7f
`define TPU_MASK_RATE       8'h1f

// Divider taps: log2 of the division from the low-frequency clock
`define TPU_TAP_2HZ         5'd14
`define TPU_TAP_8HZ         5'd12
`define TPU_TAP_64HZ        5'd9
`define TPU_TAP_256HZ       5'd7
`define TPU_TAP_2048HZ      5'd4
`define TPU_TAP_LF_256      5'd8
`define TPU_TAP_LF_128      5'd7
`define TPU_TAP_LF_64       5'd6

`endif

// file: include/tpu_pkg.sv
package tpu_pkg;
    typedef logic [7:0]  tpu_byte_t;
    typedef logic [15:0] tpu_chain_t;
    typedef logic [4:0]  tpu_rate_t;
    typedef logic [4:0]  tpu_tap_t;
endpackage : tpu_pkg

// file: include/tpu_timer_if.sv
`timescale 1ns/1ns
`default_nettype none
interface tpu_timer_if;
    import tpu_pkg::*;
    logic      tick;
    logic      enable;
    logic      reload_en;
    logic      load;
    tpu_byte_t load_value;
    tpu_byte_t count;
    logic      overflow;
    modport ctrl  (output tick, enable, reload_en, load, load_value,
                   input  count, overflow);
    modport timer (input  tick, enable, reload_en, load, load_value,
                   output count, overflow);
endinterface : tpu_timer_if
`default_nettype wire

// file: verification/tpu_timer_prescaler_unit_checker.sv
`timescale 1ns/1ns
`default_nettype none
module tpu_timer_prescaler_unit_checker
    import tpu_pkg::*;
(
    // Clock and reset
    input wire logic               clk,
    input wire logic               reset,
    // Register port
    input wire tpu_pkg::tpu_byte_t bus_addr,
    input wire tpu_pkg::tpu_byte_t bus_wdata,
    input wire logic               bus_wr,
    input wire logic               bus_rd,
    input wire tpu_pkg::tpu_byte_t bus_rdata,
    // Pins and processor state
    input wire logic               external_event_input,
    input wire logic               low_freq_clock,
    input wire logic               baud_gen_clock,
    input wire logic               cpu_standby,
    // Interrupt requests
    input wire logic               timer0_irq_request,
    input wire logic               timer1_irq_request,
    input wire logic               base_timer_irq_request
);
    import tpu_pkg::*;
    // Shadows of the control writes, so claims can be gated on them
    tpu_byte_t psc_reg;
    tpu_byte_t ien_reg;
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            psc_reg <= 8'h00;
            ien_reg <= 8'h00;
        end
        else
        begin
            if (bus_wr && bus_addr == 8'h23) psc_reg <= bus_wdata;
            if (bus_wr && bus_addr == 8'h3e) ien_reg <= bus_wdata;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
        else $error("read data seen outside the answer cycle");
    a_unmapped_zero: assert property (bus_rd && !(bus_addr inside {8'h20, 8'h21, 8'h23,
        8'h24, 8'h25, 8'h26, 8'h27, 8'h3c, 8'h3e}) |=> bus_rdata == 8'h00)
        else $error("unmapped read returned data");
    a_clear_zero: assert property (bus_wr && bus_addr == 8'h23 && bus_wdata[7:6] == 2'b10
        ##1 bus_rd && bus_addr == 8'h23 |=> bus_rdata == 8'h00)
        else $error("prescaler not zero after clear");
    a_stop_hold: assert property (!psc_reg[6] && bus_rd && bus_addr == 8'h23
        ##1 bus_rd && bus_addr == 8'h23 |=> $stable(bus_rdata))
        else $error("stopped prescaler moved");
    a_run_step: assert property ($past(psc_reg[6]) && psc_reg[6:5] == 2'b10 && bus_rd
        && bus_addr == 8'h23 ##1 bus_rd && bus_addr == 8'h23
        |=> bus_rdata == $past(bus_rdata) + 8'h01)
        else $error("prescaler did not step once per clock");
    a_t0_gated: assert property ($rose(timer0_irq_request) |-> $past(ien_reg[2])
        || ($past(bus_wr) && $past(bus_addr) == 8'h3c && $past(bus_wdata[2])))
        else $error("timer0 request raised while disabled");
    a_t1_gated: assert property ($rose(timer1_irq_request) |-> $past(ien_reg[3])
        || ($past(bus_wr) && $past(bus_addr) == 8'h3c && $past(bus_wdata[3])))
        else $error("timer1 request raised while disabled");
    a_base_gated: assert property ($rose(base_timer_irq_request) |-> $past(ien_reg[5])
        || ($past(bus_wr) && $past(bus_addr) == 8'h3c && $past(bus_wdata[5])))
        else $error("base request raised while disabled");
    a_req_readback: assert property (bus_rd && bus_addr == 8'h3c |=>
        {bus_rdata[5], bus_rdata[3:2]} == $past({base_timer_irq_request,
        timer1_irq_request, timer0_irq_request}))
        else $error("request register disagrees with request pins");
    // A quiet slow clock rules out a rate firing at the clear, which would win
    a_status_clear: assert property ($stable(low_freq_clock) [*6] ##0 (bus_wr
        && bus_addr == 8'h21 && bus_wdata[7]) ##1 (bus_rd && bus_addr == 8'h21)
        |=> bus_rdata[4:0] == 5'h00)
        else $error("base status not cleared");
endmodule : tpu_timer_prescaler_unit_checker

bind tpu_timer_prescaler_unit tpu_timer_prescaler_unit_checker i_checker
(
    .clk(clk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .external_event_input(external_event_input), .low_freq_clock(low_freq_clock),
    .baud_gen_clock(baud_gen_clock), .cpu_standby(cpu_standby),
    .timer0_irq_request(timer0_irq_request), .timer1_irq_request(timer1_irq_request),
    .base_timer_irq_request(base_timer_irq_request)
);
`default_nettype wire

// file: verification/tpu_timer_prescaler_unit_tb.sv
`timescale 1ns/1ns
`default_nettype none
module tpu_timer_prescaler_unit_tb;
    import tpu_pkg::*;
    logic      clk = 1'b0;
    logic      reset = 1'b1;
    tpu_byte_t bus_addr = 8'h00;
    tpu_byte_t bus_wdata = 8'h00;
    logic      bus_wr = 1'b0;
    logic      bus_rd = 1'b0;
    tpu_byte_t bus_rdata;
    logic      external_event_input = 1'b0;
    logic      low_freq_clock = 1'b0;
    logic      baud_gen_clock = 1'b0;
    logic      cpu_standby = 1'b0;
    wire [2:0] irqs;
    logic      lf_run = 1'b0;
    int        err_count = 0;
    int        comparisons = 0;
    int        cycles = 0;
    int        lf_div = 0;

    tpu_timer_prescaler_unit i_dut
    (
        .clk(clk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .external_event_input(external_event_input), .low_freq_clock(low_freq_clock),
        .baud_gen_clock(baud_gen_clock), .cpu_standby(cpu_standby),
        .timer0_irq_request(irqs[0]), .timer1_irq_request(irqs[1]),
        .base_timer_irq_request(irqs[2])
    );

    always #50 clk = ~clk;
    // Slow clock sped up to ten system clocks so the base rates fit the run
    always @(posedge clk)
    begin
        lf_div <= (lf_div + 1) % 5;
        if (lf_run && lf_div == 0)
            low_freq_clock <= ~low_freq_clock;
    end
    ////////////////////////////////////////
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string n, input tpu_byte_t s, input tpu_byte_t e);
        comparisons++;
        if (s !== e)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, s);
        end
    endtask : chk

    task automatic wr(input tpu_byte_t a, input tpu_byte_t d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
        @(posedge clk);
    endtask : wr

    // Two reads back to back; each answer is taken in the cycle it stands
    task automatic rd2(input tpu_byte_t a, output tpu_byte_t d1, output tpu_byte_t d2);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        bus_rd <= 1'b0;
        d1 = bus_rdata;
        @(posedge clk);
        d2 = bus_rdata;
    endtask : rd2

    task automatic wrr(input tpu_byte_t a, input tpu_byte_t d, input tpu_byte_t ra,
                       output tpu_byte_t q);
        tpu_byte_t z;
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
        rd2(ra, q, z);
    endtask : wrr

    // Reads taken gap+3 cycles apart
    task automatic measure(input tpu_byte_t ca, input int gap, output tpu_byte_t d);
        tpu_byte_t x, y, z;
        rd2(ca, x, z);
        repeat (gap) @(posedge clk);
        rd2(ca, y, z);
        d = y - x;
    endtask : measure

    task automatic edges(input logic b, input int n);
        repeat (n)
        begin
            {baud_gen_clock, external_event_input} <= b ? 2'b10 : 2'b01;
            repeat (4) @(posedge clk);
            {baud_gen_clock, external_event_input} <= 2'b00;
            repeat (4) @(posedge clk);
        end
    endtask : edges

    task automatic wt(input int i, input int lim);
        int n = 0;
        while (irqs[i] !== 1'b1 && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        chk("irq request", {7'h00, irqs[i]}, 8'h01);
    endtask : wt

    // Ceiling well above the longest path through the base-rate waits
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_count++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////
    initial
    begin
        tpu_byte_t a, b, c, ca;
        tpu_byte_t regs [10] = '{8'h20, 8'h21, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27,
                                 8'h3c, 8'h3e, 8'h22};
        tpu_byte_t ma [5] = '{8'h24, 8'h26, 8'h20, 8'h3e, 8'h3c};
        tpu_byte_t mk [5] = '{8'h37, 8'h1f, 8'h1f, 8'h7f, 8'h7f};
        tpu_byte_t t0m [9] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h07};
        tpu_byte_t t0e [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h08, 8'h20, 8'h80, 8'h00};
        tpu_byte_t tm [4] = '{8'h27, 8'h37, 8'h07, 8'h17};
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        foreach (regs[i])
        begin
            rd2(regs[i], a, b);
            chk("reset value", a, 8'h00);
        end
        wr(8'h22, 8'hff);
        rd2(8'h22, a, b);
        chk("unmapped read", a, 8'h00);
        foreach (ma[i])
        begin
            wr(ma[i], 8'hff);
            rd2(ma[i], a, b);
            chk("masked read", a, mk[i]);
        end
        chk("irq pins", {5'h00, irqs}, 8'h07);
        foreach (ma[i])
            wr(ma[i], 8'h00);
        wr(8'h23, 8'h40);
        rd2(8'h23, a, b);
        chk("prescaler step", b, a + 8'h01);
        wr(8'h23, 8'h00);
        rd2(8'h23, a, b);
        chk("prescaler stop", b, a);
        wrr(8'h23, 8'h80, 8'h23, a);
        chk("prescaler clear", a, 8'h00);
        // 257 events: one carry out of the prescaler steps timer 1 once
        wr(8'h26, 8'h04);
        wr(8'h27, 8'h00);
        wr(8'h23, 8'he0);
        edges(1'b0, 257);
        repeat (6) @(posedge clk);
        rd2(8'h23, a, b);
        chk("event count", a, 8'h01);
        rd2(8'h27, a, b);
        chk("chained count", a, 8'h01);
        for (int k = 0; k < 9; k++)
        begin
            wr(8'h23, 8'hc0);
            wr(8'h24, t0m[k]);
            measure(8'h25, 253, a);
            chk("timer0 rate", a, t0e[k]);
        end
        wr(8'h3e, 8'h0c);
        for (int t = 0; t < 4; t++)
        begin
            ca = (t < 2) ? 8'h25 : 8'h27;
            wr(ca - 8'h01, tm[t]);
            wr(ca, 8'hfc);
            wr(8'h3c, 8'h00);
            wt(t / 2, 40);
            rd2(ca, a, b);
            chk("count after wrap", a & 8'hf0, t[0] ? 8'hf0 : 8'h00);
        end
        wr(8'h24, 8'h00);
        cpu_standby <= 1'b1;
        measure(8'h27, 20, a);
        chk("timer1 in standby", a, 8'h00);
        cpu_standby <= 1'b0;
        lf_run <= 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            wr(8'h26, 8'h08 + 8'(k));
            measure(8'h27, 2557, a);
            chk("timer1 slow clock", a, 8'h01 << k);
        end
        wr(8'h26, 8'h0b);
        rd2(8'h27, a, b);
        edges(1'b1, 5);
        repeat (6) @(posedge clk);
        rd2(8'h27, c, b);
        chk("timer1 baud clock", c - a, 8'h05);
        // Base rates keep going in standby
        cpu_standby <= 1'b1;
        wr(8'h3e, 8'h20);
        for (int i = 2; i < 5; i++)
        begin
            lf_run <= 1'b0;
            repeat (10) @(posedge clk);
            wrr(8'h21, 8'h80, 8'h21, a);
            chk("status clear", a, 8'h00);
            wr(8'h3c, 8'h00);
            wr(8'h20, 8'h01 << i);
            lf_run <= 1'b1;
            wt(2, 5200);
            rd2(8'h21, a, b);
            chk("base status", a, 8'h01 << i);
        end
        report_and_stop();
    end
endmodule : tpu_timer_prescaler_unit_tb
`default_nettype wire

// file: verilog/tpu_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module tpu_pin_sync
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Asynchronous pin and its rising-edge pulse
    input  wire logic pin_in,
    output logic      rise
);
    logic [2:0] sync_reg;
    logic [2:0] sync_next;
    logic       level_reg;
    logic       level_next;
    logic       rise_reg;
    logic       rise_next;

    always_comb
    begin
        sync_next  = {sync_reg[1:0], pin_in};
        level_next = level_reg;
        rise_next  = 1'b0;
        // A change counts only once stages two and three agree
        if (sync_reg[1] == sync_reg[2])
        begin
            level_next = sync_reg[2];
            rise_next  = sync_reg[2] & ~level_reg;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sync_reg  <= 3'h0;
            level_reg <= 1'b0;
            rise_reg  <= 1'b0;
        end
        else
        begin
            sync_reg  <= sync_next;
            level_reg <= level_next;
            rise_reg  <= rise_next;
        end
    end

    assign rise = rise_reg;
endmodule : tpu_pin_sync
`default_nettype wire

// file: verilog/tpu_timer8.sv
`timescale 1ns/1ns
`default_nettype none
`include "tpu_defines.svh"
module tpu_timer8
    import tpu_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Control side
    tpu_timer_if.timer tif
);
    tpu_byte_t count_reg;
    tpu_byte_t count_next;
    tpu_byte_t reload_reg;
    tpu_byte_t reload_next;
    logic      step;

    // A software load wins over a count tick in the same cycle
    assign step         = tif.tick & tif.enable & ~tif.load;
    assign tif.overflow = step & (count_reg == 8'hff);
    assign tif.count    = count_reg;

    always_comb
    begin
        count_next  = count_reg;
        reload_next = reload_reg;
        if (tif.load)
        begin
            count_next  = tif.load_value;
            reload_next = tif.load_value;
        end
        else if (tif.overflow)
        begin
            count_next = tif.reload_en ? reload_reg : 8'h00;
        end
        else if (step)
        begin
            count_next = count_reg + 8'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            count_reg  <= `TPU_RST_BYTE;
            reload_reg <= `TPU_RST_BYTE;
        end
        else
        begin
            count_reg  <= count_next;
            reload_reg <= reload_next;
        end
    end
endmodule : tpu_timer8
`default_nettype wire

// file: verilog/tpu_timer_prescaler_unit.sv
`timescale 1ns/1ns
`default_nettype none
`include "tpu_defines.svh"
module tpu_timer_prescaler_unit
    import tpu_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          reset,
    // Register port
    input  wire tpu_pkg::tpu_byte_t bus_addr,
    input  wire tpu_pkg::tpu_byte_t bus_wdata,
    input  wire logic          bus_wr,
    input  wire logic          bus_rd,
    output tpu_pkg::tpu_byte_t bus_rdata,
    // Pins and clocks from outside this domain
    input  wire logic          external_event_input,
    input  wire logic          low_freq_clock,
    input  wire logic          baud_gen_clock,
    // Processor state
    input  wire logic          cpu_standby,
    // Interrupt requests
    output logic               timer0_irq_request,
    output logic               timer1_irq_request,
    output logic               base_timer_irq_request
);
    import tpu_pkg::*;

    ////////////////////////////////////////////////////////////////////////////

    localparam int RATES = 5;

    // Carry out of the low k bits of a chain on its next event
    function automatic logic tpu_carry(input tpu_chain_t cnt, input tpu_tap_t k);
        tpu_chain_t mask;
        mask = tpu_chain_t'((17'h1 << k) - 17'h1);
        return &(cnt | ~mask);
    endfunction : tpu_carry

    // Timer-clock division code to chain tap
    function automatic tpu_tap_t tpu_prescaled_timer_clock_tap(input logic [2:0] code);
        tpu_tap_t k;
        k = 5'd16;
        case (code)
            3'h0:    k = 5'd16;
            3'h1:    k = 5'd15;
            3'h2:    k = 5'd13;
            3'h3:    k = 5'd11;
            3'h4:    k = 5'd8;
            3'h5:    k = 5'd5;
            3'h6:    k = 5'd3;
            3'h7:    k = 5'd1;
            default: k = 5'd16;
        endcase
        return k;
    endfunction : tpu_prescaled_timer_clock_tap

    // Decoded write to one register offset
    function automatic logic tpu_wr_hit(input logic wr, input tpu_byte_t addr,
                                        input tpu_byte_t ofs);
        return wr & (addr == ofs);
    endfunction : tpu_wr_hit

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic ext_rise;
    logic lf_rise;
    logic bgr_rise;

    tpu_pin_sync u_sync_ext
    (
        .clk    (clk),
        .reset  (reset),
        .pin_in (external_event_input),
        .rise   (ext_rise)
    );

    tpu_pin_sync u_sync_lf
    (
        .clk    (clk),
        .reset  (reset),
        .pin_in (low_freq_clock),
        .rise   (lf_rise)
    );

    tpu_pin_sync u_sync_bgr
    (
        .clk    (clk),
        .reset  (reset),
        .pin_in (baud_gen_clock),
        .rise   (bgr_rise)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register state

    tpu_rate_t  base_en_reg;
    tpu_rate_t  base_en_next;
    tpu_rate_t  base_stat_reg;
    tpu_rate_t  base_stat_next;
    logic       presc_run_reg;
    logic       presc_run_next;
    logic       presc_src_reg;
    logic       presc_src_next;
    tpu_chain_t prescaled_timer_clock_cnt_reg;
    tpu_chain_t prescaled_timer_clock_cnt_next;
    tpu_chain_t lf_cnt_reg;
    tpu_chain_t lf_cnt_next;
    tpu_byte_t  t0_mode_reg;
    tpu_byte_t  t0_mode_next;
    tpu_byte_t  t1_mode_reg;
    tpu_byte_t  t1_mode_next;
    tpu_byte_t  irq_req_reg;
    tpu_byte_t  irq_req_next;
    tpu_byte_t  irq_en_reg;
    tpu_byte_t  irq_en_next;
    tpu_byte_t  rdata_reg;
    tpu_byte_t  rdata_next;

    logic       wr_presc;
    logic       wr_stat;
    logic       prescaled_timer_clock_ev;
    tpu_rate_t  rate_ovf;
    tpu_rate_t  rate_hit;
    logic       bt_event;
    logic       t1_tick;

    tpu_timer_if t0_if ();
    tpu_timer_if t1_if ();

    localparam tpu_tap_t RATE_TAP [RATES] = '{`TPU_TAP_2HZ, `TPU_TAP_8HZ,
        `TPU_TAP_64HZ, `TPU_TAP_256HZ, `TPU_TAP_2048HZ};

    assign wr_presc = tpu_wr_hit(bus_wr, bus_addr, `TPU_OFS_PRESC);
    assign wr_stat  = tpu_wr_hit(bus_wr, bus_addr, `TPU_OFS_BASE_STAT);

    ////////////////////////////////////////////////////////////////////////////
    // Prescalers

    // Timer clock event: system clock every cycle or a synchronised edge
    assign prescaled_timer_clock_ev = presc_run_reg & (presc_src_reg ? ext_rise : 1'b1);

    always_comb
    begin
        presc_run_next = presc_run_reg;
        presc_src_next = presc_src_reg;
        prescaled_timer_clock_cnt_next  = prescaled_timer_clock_cnt_reg;
        if (prescaled_timer_clock_ev)
        begin
            prescaled_timer_clock_cnt_next = prescaled_timer_clock_cnt_reg + 16'h0001;
        end
        if (wr_presc)
        begin
            presc_run_next = bus_wdata[`TPU_BIT_PRESC_RUN];
            presc_src_next = bus_wdata[`TPU_BIT_PRESC_SRC];
            if (bus_wdata[`TPU_BIT_PRESC_CLEAR])
            begin
                prescaled_timer_clock_cnt_next = 16'h0000;
            end
        end
        // The low chain ignores software and standby entirely
        lf_cnt_next = lf_rise ? lf_cnt_reg + 16'h0001 : lf_cnt_reg;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            presc_run_reg <= 1'b0;
            presc_src_reg <= 1'b0;
            prescaled_timer_clock_cnt_reg  <= 16'h0000;
            lf_cnt_reg    <= 16'h0000;
        end
        else
        begin
            presc_run_reg <= presc_run_next;
            presc_src_reg <= presc_src_next;
            prescaled_timer_clock_cnt_reg  <= prescaled_timer_clock_cnt_next;
            lf_cnt_reg    <= lf_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Base timer

    always_comb
    begin
        for (int i = 0; i < RATES; i++)
        begin
            rate_ovf[i] = lf_rise & tpu_carry(lf_cnt_reg, RATE_TAP[i]);
        end
    end

    assign rate_hit = rate_ovf & base_en_reg;
    assign bt_event = |rate_hit;

    always_comb
    begin
        base_en_next   = base_en_reg;
        base_stat_next = base_stat_reg;
        if (tpu_wr_hit(bus_wr, bus_addr, `TPU_OFS_BASE_EN))
        begin
            base_en_next = bus_wdata[4:0];
        end
        // Software must clear after service, or later rates pile up here
        if (wr_stat && bus_wdata[`TPU_BIT_STAT_CLEAR])
        begin
            base_stat_next = 5'h00;
        end
        // A rate that fires in the clearing cycle is kept
        base_stat_next = base_stat_next | rate_hit;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            base_en_reg   <= 5'h00;
            base_stat_reg <= 5'h00;
        end
        else
        begin
            base_en_reg   <= base_en_next;
            base_stat_reg <= base_stat_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timer 0 and timer 1

    assign t0_if.tick       = prescaled_timer_clock_ev & tpu_carry(prescaled_timer_clock_cnt_reg,
                                                  tpu_prescaled_timer_clock_tap(t0_mode_reg[2:0]));
    assign t0_if.enable     = t0_mode_reg[`TPU_BIT_T0_ENABLE];
    assign t0_if.reload_en  = t0_mode_reg[`TPU_BIT_TM_RELOAD];
    assign t0_if.load       = tpu_wr_hit(bus_wr, bus_addr, `TPU_OFS_T0_COUNT);
    assign t0_if.load_value = bus_wdata;

    // At divide-by-256 timer 1 steps on each prescaler carry, so with the
    // external source the pair is one 16-bit event counter
    always_comb
    begin
        t1_tick = 1'b0;
        if (!t1_mode_reg[`TPU_BIT_T1_LF])
        begin
            t1_tick = prescaled_timer_clock_ev & tpu_carry(prescaled_timer_clock_cnt_reg,
                                          tpu_prescaled_timer_clock_tap(t1_mode_reg[2:0]));
        end
        else
        begin
            case (t1_mode_reg[2:0])
                3'h0:    t1_tick = lf_rise & tpu_carry(lf_cnt_reg, `TPU_TAP_LF_256);
                3'h1:    t1_tick = lf_rise & tpu_carry(lf_cnt_reg, `TPU_TAP_LF_128);
                3'h2:    t1_tick = lf_rise & tpu_carry(lf_cnt_reg, `TPU_TAP_LF_64);
                3'h3:    t1_tick = bgr_rise;
                default: t1_tick = 1'b0;
            endcase
        end
    end

    assign t1_if.tick       = t1_tick;
    assign t1_if.enable     = ~cpu_standby;
    assign t1_if.reload_en  = t1_mode_reg[`TPU_BIT_TM_RELOAD];
    assign t1_if.load       = tpu_wr_hit(bus_wr, bus_addr, `TPU_OFS_T1_COUNT);
    assign t1_if.load_value = bus_wdata;

    tpu_timer8 u_timer0
    (
        .clk   (clk),
        .reset (reset),
        .tif   (t0_if.timer)
    );

    tpu_timer8 u_timer1
    (
        .clk   (clk),
        .reset (reset),
        .tif   (t1_if.timer)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Modes and interrupt registers

    always_comb
    begin
        t0_mode_next = t0_mode_reg;
        t1_mode_next = t1_mode_reg;
        irq_en_next  = irq_en_reg;
        irq_req_next = irq_req_reg;
        if (tpu_wr_hit(bus_wr, bus_addr, `TPU_OFS_T0_MODE))
        begin
            t0_mode_next = bus_wdata & `TPU_MASK_T0_MODE;
        end
        if (tpu_wr_hit(bus_wr, bus_addr, `TPU_OFS_T1_MODE))
        begin
            t1_mode_next = bus_wdata & `TPU_MASK_T1_MODE;
        end
        if (tpu_wr_hit(bus_wr, bus_addr, `TPU_OFS_IRQ_EN))
        begin
            irq_en_next = bus_wdata & `TPU_MASK_IRQ;
        end
        if (tpu_wr_hit(bus_wr, bus_addr, `TPU_OFS_IRQ_REQ))
        begin
            irq_req_next = bus_wdata & `TPU_MASK_IRQ;
        end
        // Events are ORed in after the write so a set is never lost
        if (t0_if.overflow && irq_en_reg[`TPU_BIT_IRQ_T0])
        begin
            irq_req_next[`TPU_BIT_IRQ_T0] = 1'b1;
        end
        if (t1_if.overflow && irq_en_reg[`TPU_BIT_IRQ_T1])
        begin
            irq_req_next[`TPU_BIT_IRQ_T1] = 1'b1;
        end
        if (bt_event && irq_en_reg[`TPU_BIT_IRQ_BT])
        begin
            irq_req_next[`TPU_BIT_IRQ_BT] = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            t0_mode_reg <= `TPU_RST_BYTE;
            t1_mode_reg <= `TPU_RST_BYTE;
            irq_en_reg  <= `TPU_RST_BYTE;
            irq_req_reg <= `TPU_RST_BYTE;
        end
        else
        begin
            t0_mode_reg <= t0_mode_next;
            t1_mode_reg <= t1_mode_next;
            irq_en_reg  <= irq_en_next;
            irq_req_reg <= irq_req_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port: data stand one cycle after the strobe, zero otherwise

    always_comb
    begin
        rdata_next = 8'h00;
        if (bus_rd)
        begin
            case (bus_addr)
                `TPU_OFS_BASE_EN:   rdata_next = {3'h0, base_en_reg};
                `TPU_OFS_BASE_STAT: rdata_next = {3'h0, base_stat_reg};
                `TPU_OFS_PRESC:     rdata_next = prescaled_timer_clock_cnt_reg[7:0];
                `TPU_OFS_T0_MODE:   rdata_next = t0_mode_reg;
                `TPU_OFS_T0_COUNT:  rdata_next = t0_if.count;
                `TPU_OFS_T1_MODE:   rdata_next = t1_mode_reg;
                `TPU_OFS_T1_COUNT:  rdata_next = t1_if.count;
                `TPU_OFS_IRQ_REQ:   rdata_next = irq_req_reg;
                `TPU_OFS_IRQ_EN:    rdata_next = irq_en_reg;
                default:            rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rdata_reg <= 8'h00;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    assign bus_rdata              = rdata_reg;
    assign timer0_irq_request     = irq_req_reg[`TPU_BIT_IRQ_T0];
    assign timer1_irq_request     = irq_req_reg[`TPU_BIT_IRQ_T1];
    assign base_timer_irq_request = irq_req_reg[`TPU_BIT_IRQ_BT];
endmodule : tpu_timer_prescaler_unit
`default_nettype wire
